/* shared/adcsq_pkg.sv */
package adcsq_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CONTROL_0 = 8'h00;
    localparam logic [7:0] OFS_CONTROL_1 = 8'h04;
    localparam logic [7:0] OFS_CONTROL_2 = 8'h08;
    localparam logic [7:0] OFS_RESULT_HI = 8'h0c;
    localparam logic [7:0] OFS_RESULT_LO = 8'h10;
    localparam logic [7:0] OFS_STATUS    = 8'h14;
    localparam logic [7:0] OFS_MASK      = 8'h18;
    // control 0 fields
    localparam int BIT_ENABLE = 0;
    localparam int BIT_START  = 1;
    localparam int CHAN_LSB   = 2;
    localparam int CHAN_W     = 4;
    // control 1 fields
    localparam int BIT_VREF_POS = 4;
    localparam int BIT_VREF_NEG = 5;
    // control 2 fields
    localparam int CS_LSB   = 0;
    localparam int ACQ_LSB  = 3;
    localparam int BIT_RJST = 7;
    // field codes
    localparam logic [2:0] ACQ_MANUAL = 3'h0;
    localparam logic [1:0] CS_RC      = 2'h3;
    localparam int RES_W      = 12;
    localparam int CONV_TADS  = 13;
    localparam logic [4:0] CONV_TADS_M1 = 5'h0c;
    // control 1 reset: all shared pins analog
    localparam logic [15:0] CTRL1_RESET = 16'hffff;
    typedef enum logic [3:0] {
        ADCSQ_IDLE = 4'b0001,
        ADCSQ_ACQ  = 4'b0010,
        ADCSQ_CONV = 4'b0100,
        ADCSQ_DONE = 4'b1000
    } adcsq_state_t;
endpackage

/* hw/adcsq_tad_gen.sv */
`timescale 1ns/1ps
// conversion clock period tick, from the bus clock or the rc oscillator
module adcsq_tad_gen
(
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       run,
    input  wire logic [2:0] clock_select,
    input  wire logic       rc_tick_in,
    output logic            tad_tick
);
    logic [6:0] div_count;
    logic [6:0] div_last;
    logic       rc_meta;
    logic       rc_sync;
    logic       rc_prev;
    wire        use_rc   = (clock_select[1:0] == adcsq_pkg::CS_RC);
    wire        rc_edge  = rc_sync & ~rc_prev;
    wire        div_hit  = (div_count == div_last);
    // divider 2 shl {bit1:0,bit2 order}: 000=2,100=4,001=8,101=16,010=32,110=64
    assign div_last = 7'((7'h2 << {clock_select[1:0], clock_select[2]}) - 7'h1);
    // rc oscillator is asynchronous, so it is synchronised before edge detect
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rc_meta   <= 1'b0;
            rc_sync   <= 1'b0;
            rc_prev   <= 1'b0;
            div_count <= 7'h00;
            tad_tick  <= 1'b0;
        end
        else
        begin
            rc_meta   <= rc_tick_in;
            rc_sync   <= rc_meta;
            rc_prev   <= rc_sync;
            div_count <= (!run || div_hit) ? 7'h00 : 7'(div_count + 7'h1);
            tad_tick  <= run & (use_rc ? rc_edge : div_hit);
        end
    end
endmodule // adcsq_tad_gen

/* hw/adcsq_sar.sv */
`timescale 1ns/1ps
// successive approximation register, one decision per tick
module adcsq_sar #(parameter int WIDTH = 12)
(
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             begin_search,
    input  wire logic             bit_tick,
    input  wire logic             comp_above,
    output logic [WIDTH-1:0]      trial,
    output logic                  search_done
);
    logic [WIDTH-1:0] probe;
    // keep trial bit only if held sample is above the trial level
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            trial       <= '0;
            probe       <= '0;
            search_done <= 1'b0;
        end
        else if (begin_search)
        begin
            trial       <= {1'b1, {(WIDTH-1){1'b0}}};
            probe       <= {1'b1, {(WIDTH-1){1'b0}}};
            search_done <= 1'b0;
        end
        else if (bit_tick && probe != '0)
        begin
            trial <= (comp_above ? trial : (trial & ~probe)) | (probe >> 1);
            probe <= probe >> 1;
            search_done <= (probe[0] == 1'b1);
        end
    end
endmodule // adcsq_sar

/* hw/adcsq_top.sv */
`timescale 1ns/1ps
// converter sequencing control with an ahb-lite register slave
module adcsq_top #(parameter int PINS = 16)
(
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             hsel,
    input  wire logic [7:0]       haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic [31:0]           hrdata,
    output logic                  hreadyout,
    output logic                  hresp,
    input  wire logic             comp_above,
    input  wire logic             rc_osc,
    output logic [11:0]           dac_trial,
    output logic                  sample_switch,
    output logic [3:0]            channel_select,
    output logic                  vref_pos_pin,
    output logic                  vref_neg_pin,
    output logic [PINS-1:0]       pin_analog,
    output logic                  converter_on,
    output logic                  irq
);
    logic [7:0]              converter_control_0;
    logic [PINS-1:0]         pin_config;
    logic [7:0]              converter_control_1;
    logic [7:0]              converter_control_2;
    logic [7:0]              result_high_byte;
    logic [7:0]              result_low_byte;
    logic                    conversion_irq_flag;
    logic                    irq_mask;
    logic                    cmp_sync;
    logic                    wr_pend;
    logic                    rd_pend;
    logic [7:0]              addr_q;
    logic [4:0]              tad_count;
    adcsq_pkg::adcsq_state_t state;
    adcsq_pkg::adcsq_state_t next_state;
    logic                    tad_tick;
    logic [11:0]             trial;
    logic                    search_done;

    wire       enabled   = converter_control_0[adcsq_pkg::BIT_ENABLE];
    wire       start_bit = converter_control_0[adcsq_pkg::BIT_START];
    wire [2:0] acq_code  = converter_control_2[adcsq_pkg::ACQ_LSB +: 3];
    wire [2:0] cs_code   = converter_control_2[adcsq_pkg::CS_LSB +: 3];
    wire       take      = hsel & hready & htrans[1];
    wire       finish    = (state == adcsq_pkg::ADCSQ_DONE);
    wire       run_clock = enabled & (state != adcsq_pkg::ADCSQ_IDLE);

    // acquisition length in periods: 1..7 map to 2,4,6,8,12,16,20
    function automatic logic [4:0] acq_periods(input logic [2:0] code);
        case (code)
            3'h1:    acq_periods = 5'h02;
            3'h2:    acq_periods = 5'h04;
            3'h3:    acq_periods = 5'h06;
            3'h4:    acq_periods = 5'h08;
            3'h5:    acq_periods = 5'h0c;
            3'h6:    acq_periods = 5'h10;
            default: acq_periods = 5'h14;
        endcase
    endfunction

    adcsq_tad_gen u_tad
    (
        .hclk         (hclk),
        .hresetn      (hresetn),
        .run          (run_clock),
        .clock_select (cs_code),
        .rc_tick_in   (rc_osc),
        .tad_tick     (tad_tick)
    );

    adcsq_sar #(.WIDTH(adcsq_pkg::RES_W)) u_sar
    (
        .hclk         (hclk),
        .hresetn      (hresetn),
        .begin_search (state == adcsq_pkg::ADCSQ_ACQ && next_state == adcsq_pkg::ADCSQ_CONV
                       || state == adcsq_pkg::ADCSQ_IDLE && next_state == adcsq_pkg::ADCSQ_CONV),
        .bit_tick     (tad_tick && state == adcsq_pkg::ADCSQ_CONV
                       && tad_count != 5'h00),
        .comp_above   (cmp_sync),
        .trial        (trial),
        .search_done  (search_done)
    );

    // sequencer: manual code skips acquisition, auto codes count periods
    always_comb
    begin
        next_state = state;
        case (state)
            adcsq_pkg::ADCSQ_IDLE:
                if (enabled && start_bit)
                    next_state = (acq_code == adcsq_pkg::ACQ_MANUAL)
                               ? adcsq_pkg::ADCSQ_CONV : adcsq_pkg::ADCSQ_ACQ;
            adcsq_pkg::ADCSQ_ACQ:
                if (tad_tick && tad_count == 5'(acq_periods(acq_code) - 5'h1))
                    next_state = adcsq_pkg::ADCSQ_CONV;
            adcsq_pkg::ADCSQ_CONV:
                if (tad_tick && tad_count == adcsq_pkg::CONV_TADS_M1)
                    next_state = adcsq_pkg::ADCSQ_DONE;
            adcsq_pkg::ADCSQ_DONE:
                next_state = adcsq_pkg::ADCSQ_IDLE;
            default:
                next_state = adcsq_pkg::ADCSQ_IDLE;
        endcase
        if (!enabled)
            next_state = adcsq_pkg::ADCSQ_IDLE;
    end

    // state and period counter; counter restarts on each phase change
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state     <= adcsq_pkg::ADCSQ_IDLE;
            tad_count <= 5'h00;
        end
        else
        begin
            state     <= next_state;
            tad_count <= (next_state != state) ? 5'h00
                       : (tad_tick ? 5'(tad_count + 5'h1) : tad_count);
        end
    end

    // comparator answers the trial code we drive; one flop only, since a
    // deeper chain would miss the next decision at a two-clock period
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cmp_sync <= 1'b0;
        end
        else
        begin
            cmp_sync <= comp_above;
        end
    end

    // ahb-lite address phase capture; zero wait states
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            addr_q  <= 8'h00;
        end
        else
        begin
            wr_pend <= take & hwrite;
            rd_pend <= take & ~hwrite;
            addr_q  <= haddr;
        end
    end

    wire wr_c0 = wr_pend && addr_q == adcsq_pkg::OFS_CONTROL_0;
    wire wr_c1 = wr_pend && addr_q == adcsq_pkg::OFS_CONTROL_1;
    wire wr_c2 = wr_pend && addr_q == adcsq_pkg::OFS_CONTROL_2;
    wire wr_mk = wr_pend && addr_q == adcsq_pkg::OFS_MASK;
    wire rd_st = rd_pend && addr_q == adcsq_pkg::OFS_STATUS;
    // result alignment: right-justified or left-justified 12 bits
    wire [15:0] res_word = converter_control_2[adcsq_pkg::BIT_RJST]
                         ? {4'h0, trial} : {trial, 4'h0};
    // trial code leaves straight from the search flops, saving a cycle
    assign dac_trial = trial;

    // registers; completion beats a same-cycle software write of start
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            converter_control_0 <= 8'h00;
            converter_control_1 <= 8'h00;
            converter_control_2 <= 8'h00;
            pin_config          <= adcsq_pkg::CTRL1_RESET;
            result_high_byte    <= 8'h00;
            result_low_byte     <= 8'h00;
            conversion_irq_flag <= 1'b0;
            irq_mask            <= 1'b0;
        end
        else
        begin
            if (wr_c0)
                converter_control_0 <= hwdata[7:0];
            if (finish || (!enabled && !wr_c0))
                converter_control_0[adcsq_pkg::BIT_START] <= 1'b0;
            if (wr_c1)
            begin
                converter_control_1 <= hwdata[7:0];
                pin_config          <= hwdata[8 +: PINS];
            end
            if (wr_c2)
                converter_control_2 <= hwdata[7:0];
            if (wr_mk)
                irq_mask <= hwdata[0];
            if (finish)
            begin
                result_high_byte <= res_word[15:8];
                result_low_byte  <= res_word[7:0];
            end
            if (finish)
                conversion_irq_flag <= 1'b1;
            else if (rd_st && hrdata[0])
                conversion_irq_flag <= 1'b0; // only a flag that was read is lost
        end
    end

    // read mux decodes the address phase so data stands in the data phase
    wire [31:0] rd_mux =
        (haddr == adcsq_pkg::OFS_CONTROL_0) ? {24'h0, converter_control_0} :
        (haddr == adcsq_pkg::OFS_CONTROL_1) ? {8'h0, pin_config, converter_control_1} :
        (haddr == adcsq_pkg::OFS_CONTROL_2) ? {24'h0, converter_control_2} :
        (haddr == adcsq_pkg::OFS_RESULT_HI) ? {24'h0, result_high_byte} :
        (haddr == adcsq_pkg::OFS_RESULT_LO) ? {24'h0, result_low_byte} :
        (haddr == adcsq_pkg::OFS_STATUS)    ? {31'h0, conversion_irq_flag} :
        (haddr == adcsq_pkg::OFS_MASK)      ? {31'h0, irq_mask} : 32'h0;

    // outputs straight from flops
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata         <= 32'h0;
            hreadyout      <= 1'b1;
            hresp          <= 1'b0;
            sample_switch  <= 1'b0;
            channel_select <= 4'h0;
            vref_pos_pin   <= 1'b0;
            vref_neg_pin   <= 1'b0;
            pin_analog     <= '1;
            converter_on   <= 1'b0;
            irq            <= 1'b0;
        end
        else
        begin
            hrdata         <= (take & ~hwrite) ? rd_mux : 32'h0;
            hreadyout      <= 1'b1;
            hresp          <= 1'b0;
            // hold closed while enabled and not converting; no phase flag exists
            sample_switch  <= enabled && next_state != adcsq_pkg::ADCSQ_CONV;
            channel_select <= converter_control_0[adcsq_pkg::CHAN_LSB +: adcsq_pkg::CHAN_W];
            vref_pos_pin   <= converter_control_1[adcsq_pkg::BIT_VREF_POS];
            vref_neg_pin   <= converter_control_1[adcsq_pkg::BIT_VREF_NEG];
            pin_analog     <= pin_config;
            converter_on   <= enabled;
            irq            <= (conversion_irq_flag | finish) & irq_mask;
        end
    end
endmodule // adcsq_top

/* testbench/adcsq_analog_model.sv */
`timescale 1ns/1ps
// pin levels, sample-and-hold capacitor and comparator
module adcsq_analog_model
(
    input  wire logic        hclk,
    input  wire logic        sample_switch,
    input  wire logic [3:0]  channel_select,
    input  wire logic [11:0] dac_trial,
    output logic             comp_above
);
    logic [11:0] held = 12'h000;
    // each pin sits half a step above a distinct code
    wire  [11:0] level = {channel_select, ~channel_select, 4'h9};
    // capacitor follows the pin only while the switch is closed
    always_ff @(posedge hclk)
    begin
        if (sample_switch)
            held <= level;
    end
    // half step up, so above the trial exactly when held >= trial
    assign comp_above = held >= dac_trial;
endmodule // adcsq_analog_model

/* testbench/adcsq_monitor.sv */
`timescale 1ns/1ps
// watches bus writes and the sample/convert handshake
module adcsq_monitor #(parameter int PINS = 16)
(
    input wire logic            hclk,
    input wire logic            hresetn,
    input wire logic            hsel,
    input wire logic [7:0]      haddr,
    input wire logic [1:0]      htrans,
    input wire logic            hwrite,
    input wire logic [31:0]     hwdata,
    input wire logic            sample_switch,
    input wire logic [3:0]      channel_select,
    input wire logic            vref_pos_pin,
    input wire logic            vref_neg_pin,
    input wire logic [PINS-1:0] pin_analog,
    input wire logic            converter_on,
    input wire logic            irq
);
    logic       wr_ph;
    logic [7:0] wr_adr;
    logic [2:0] acq_sh;
    wire        wr_c0 = wr_ph && wr_adr == adcsq_pkg::OFS_CONTROL_0;
    wire        wr_c1 = wr_ph && wr_adr == adcsq_pkg::OFS_CONTROL_1;
    // data phase trails the address phase by one edge
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_ph  <= 1'b0;
            wr_adr <= 8'h00;
            acq_sh <= 3'h0;
        end
        else
        begin
            wr_ph  <= hsel && htrans[1] && hwrite;
            wr_adr <= haddr;
            if (wr_ph && wr_adr == adcsq_pkg::OFS_CONTROL_2)
                acq_sh <= hwdata[5:3];
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_reset_state: assert property ($rose(hresetn) |-> !converter_on && !irq && &pin_analog)
        else $error("state after reset wrong");
    a_ref_follow: assert property (wr_c1 |-> ##2 {vref_neg_pin, vref_pos_pin} == $past(hwdata[5:4], 2))
        else $error("reference select not applied");
    a_pin_follow: assert property (wr_c1 |-> ##2 pin_analog == $past(hwdata[8 +: PINS], 2))
        else $error("pin mode not applied");
    a_enable_follow: assert property (wr_c0 |-> ##2 converter_on == $past(hwdata[0], 2)
        && channel_select == $past(hwdata[5:2], 2))
        else $error("enable or channel not applied");
    a_manual_start: assert property (wr_c0 && hwdata[1:0] == 2'b11 && acq_sh == 3'h0
        && sample_switch |-> ##[1:3] !sample_switch)
        else $error("manual start late");
    a_conv_min: assert property ($fell(sample_switch) && converter_on
        |=> (!sample_switch || !converter_on)[*8])
        else $error("conversion too short");
    a_conv_bound: assert property ($fell(sample_switch) && converter_on
        |-> ##[1:900] (sample_switch || !converter_on))
        else $error("conversion never ends");
    a_irq_sampling: assert property ($rose(irq) |-> sample_switch)
        else $error("flag raised while converting");
    c_conv: cover property ($fell(sample_switch) && converter_on);
    c_irq: cover property ($rose(irq));
    c_ref: cover property (wr_c1 && hwdata[4]);
endmodule // adcsq_monitor

bind adcsq_top adcsq_monitor #(.PINS(PINS)) adcsq_monitor_inst (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .sample_switch(sample_switch), .channel_select(channel_select),
    .vref_pos_pin(vref_pos_pin), .vref_neg_pin(vref_neg_pin), .pin_analog(pin_analog),
    .converter_on(converter_on), .irq(irq));

/* testbench/test_adcsq_top.sv */
`timescale 1ns/1ps
// register-level bench for the converter sequencing block
module test_adcsq_top;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        rc_osc = 1'b0;
    logic [31:0] rd;
    wire  [31:0] hrdata;
    wire  [11:0] dac_trial;
    wire  [3:0]  channel_select;
    wire  [15:0] pin_analog;
    wire         hreadyout, hresp, comp_above, sample_switch, converter_on, irq, vp, vn;
    int          n_errors = 0;
    int          cmp_count = 0;
    always #4 hclk = ~hclk;
    // internal rc oscillator, unrelated to hclk
    // four bus clocks a period, edges on falling hclk edges, clear of rising ones
    always #16 rc_osc = ~rc_osc;
    adcsq_top adcsq_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .comp_above(comp_above),
        .rc_osc(rc_osc), .dac_trial(dac_trial), .sample_switch(sample_switch),
        .channel_select(channel_select), .vref_pos_pin(vp), .vref_neg_pin(vn),
        .pin_analog(pin_analog), .converter_on(converter_on), .irq(irq));
    adcsq_analog_model adcsq_analog_model_inst (.hclk(hclk), .sample_switch(sample_switch),
        .channel_select(channel_select), .dac_trial(dac_trial), .comp_above(comp_above));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        $display("compares %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // single word transfer; results are looked at on the falling edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        @(negedge hclk);
    endtask
    task automatic tick(input int k);
        repeat (k) @(negedge hclk);
    endtask
    // cycles until sample_switch leaves level v
    task automatic span(input logic v, output int k);
        k = 0;
        while (sample_switch === v && k < 3000)
        begin
            @(negedge hclk);
            k++;
        end
    endtask
    // one conversion: timing, result pair, flag, mask and clear-on-read
    task automatic convert(input logic [2:0] cs, input logic [2:0] acq, input logic [3:0] ch,
                           input logic rj, input logic msk, input int div);
        int          na, nc, t;
        logic [11:0] r;
        r = {ch, ~ch, 4'h9};
        t = acq < 3'h5 ? 2 * acq : 4 * acq - 8;
        bus(1'b1, adcsq_pkg::OFS_MASK, {31'h0, msk});
        bus(1'b1, adcsq_pkg::OFS_CONTROL_2, {24'h0, rj, 1'b0, acq, cs});
        bus(1'b1, adcsq_pkg::OFS_CONTROL_0, {26'h0, ch, 2'b01});
        tick(4);
        bus(1'b1, adcsq_pkg::OFS_CONTROL_0, {26'h0, ch, 2'b11});
        span(1'b1, na);
        span(1'b0, nc);
        check(na + div >= t * div && na <= t * div + 2 * div + 4, 1'b1);
        check(nc >= 12 * div && nc <= 15 * div + 4, 1'b1);
        check(sample_switch, 1'b1);
        tick(2);
        check(irq, msk);
        bus(1'b0, adcsq_pkg::OFS_CONTROL_0, 32'h0);
        check(rd, {26'h0, ch, 2'b01});
        bus(1'b0, adcsq_pkg::OFS_RESULT_HI, 32'h0);
        check(rd, rj ? {28'h0, r[11:8]} : {24'h0, r[11:4]});
        bus(1'b0, adcsq_pkg::OFS_RESULT_LO, 32'h0);
        check(rd, rj ? {24'h0, r[7:0]} : {24'h0, r[3:0], 4'h0});
        bus(1'b1, adcsq_pkg::OFS_MASK, 32'h1);
        tick(2);
        check(irq, 1'b1);
        bus(1'b0, adcsq_pkg::OFS_STATUS, 32'h0);
        check(rd, 32'h1);
        tick(2);
        check(irq, 1'b0);
    endtask
    task automatic t_config;
        check({converter_on, irq, pin_analog, vp, vn}, {2'b00, 16'hffff, 2'b00});
        bus(1'b1, adcsq_pkg::OFS_CONTROL_1, 32'h00a5_3c10);
        tick(1);
        check({vp, vn, pin_analog}, {2'b10, 16'ha53c});
        bus(1'b0, adcsq_pkg::OFS_CONTROL_1, 32'h0);
        check(rd, 32'h00a5_3c10);
        bus(1'b1, adcsq_pkg::OFS_CONTROL_1, 32'h005a_c320);
        bus(1'b1, 8'h40, 32'hffff_ffff);
        bus(1'b0, 8'h40, 32'h0);
        check({rd[17:0], vp, vn, pin_analog}, {18'h0, 2'b01, 16'h5ac3});
        $display("config test done");
    endtask
    // every divider code and the rc code, every acquisition code, both justifications
    task automatic t_convert;
        logic [2:0] cs [6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
        for (int i = 0; i < 6; i++)
            convert(cs[i], 3'(i + 1), 4'(i * 3), i[0], i[1], 2 << i);
        convert(3'h0, 3'h0, 4'hf, 1'b0, 1'b1, 2);
        convert(3'h7, 3'h7, 4'h9, 1'b1, 1'b0, 4);
        $display("convert test done");
    endtask
    // switching off and resetting mid-conversion must leave no result
    task automatic t_abort;
        bus(1'b1, adcsq_pkg::OFS_CONTROL_2, 32'h6);
        bus(1'b1, adcsq_pkg::OFS_CONTROL_0, 32'h3);
        tick(100);
        bus(1'b1, adcsq_pkg::OFS_CONTROL_0, 32'h0);
        tick(900);
        check({converter_on, irq}, 2'b00);
        bus(1'b1, adcsq_pkg::OFS_CONTROL_0, 32'h3);
        tick(100);
        @(posedge hclk);
        hresetn <= 1'b0;
        tick(2);
        check({converter_on, irq, pin_analog}, {2'b00, 16'hffff});
        @(posedge hclk);
        hresetn <= 1'b1;
        tick(900);
        bus(1'b0, adcsq_pkg::OFS_CONTROL_2, 32'h0);
        check({rd, irq}, 33'h0);
        $display("abort test done");
    endtask
    initial
    begin
        tick(5);
        @(posedge hclk);
        hresetn <= 1'b1;
        t_config;
        t_convert;
        t_abort;
        end_of_test;
    end
    // whole run is near 6000 cycles; allow ten times that
    initial
    begin
        #480000;
        n_errors++;
        $display("BAD at %0t: watchdog expired", $time);
        end_of_test;
    end
endmodule // test_adcsq_top
